//--- bwc_pkg.sv
// Shared constants for the bridge window configuration register bank
package bwc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_PF_BASE_HI = 8'h28;
    localparam logic [7:0] OFF_PF_LIMIT_HI = 8'h2c;
    localparam logic [7:0] OFF_IO_HI = 8'h30;
    localparam logic [7:0] OFF_CAP_PTR = 8'h34;
    localparam logic [7:0] OFF_INT_BRIDGE = 8'h3c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h80;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h84;
    // Reset values
    localparam logic [31:0] RST_PF_HI = 32'h0000_0000;
    localparam logic [15:0] RST_IO_HI = 16'h0000;
    localparam logic [7:0] RST_CAP_PTR = 8'h40;
    localparam logic [7:0] RST_INT_LINE = 8'h00;
    localparam logic [7:0] RST_INT_PIN = 8'h00;
    localparam logic [3:0] RST_BRIDGE_CTL = 4'h0;
    localparam logic [2:0] RST_IRQ = 3'h0;
    // Field positions in the 0x3c word, plus the I/O limit half in the 0x30 word
    localparam int INT_PIN_LSB = 8;
    localparam int BC_LSB = 16;
    localparam int BC_PARITY = 0;
    localparam int BC_ERRFWD = 1;
    localparam int BC_ISA = 2;
    localparam int BC_VGA = 3;
    localparam int IO_LIMIT_LSB = 16;
    // Interrupt status bit positions
    localparam int IRQ_POISON = 0;
    localparam int IRQ_ERRFWD = 1;
    localparam int IRQ_HOTPLUG = 2;
    // Implied low address bits of the windows
    localparam logic [19:0] PF_LOW_ZERO = 20'h00000;
    localparam logic [19:0] PF_LOW_ONES = 20'hfffff;
    localparam logic [11:0] IO_LOW_ZERO = 12'h000;
    localparam logic [11:0] IO_LOW_ONES = 12'hfff;
    // Legacy ranges
    localparam logic [63:0] VGA_MEM_LO = 64'h0000_0000_000a_0000;
    localparam logic [63:0] VGA_MEM_HI = 64'h0000_0000_000b_ffff;
    localparam logic [9:0] VGA_IO_A_LO = 10'h3b0;
    localparam logic [9:0] VGA_IO_A_HI = 10'h3bb;
    localparam logic [9:0] VGA_IO_B_LO = 10'h3c0;
    localparam logic [9:0] VGA_IO_B_HI = 10'h3df;
    localparam logic [63:0] IO_64K_TOP = 64'h0000_0000_0000_ffff;
    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;
    typedef enum logic [1:0] {BWC_IDLE, BWC_RDWAIT, BWC_RDDATA} bwc_bus_t;
endpackage

//--- bwc_bridge_window_regs.sv
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// - prefetch base upper word, writable, reset zero
// - prefetch limit upper word, writable, reset zero
// - I/O base upper 16 bits in low half
// - I/O limit upper 16 bits in high half
// - read-only capability pointer resets to 0x40
// - hot-plug raises INTA; pin byte read-only zero
// - downstream ports may reload the pin byte
// - poisoned packets reported only when bit16 set
// - error messages forwarded only when bit17 set
// - ISA bit sends upper 768-byte blocks upstream
// - VGA memory range forwarded only with bit19
// - VGA I/O only within first 64KB
// - prefetch low bits implied zero and ones
module bwc_bridge_window_regs (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clkEn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Lower window halves held by the neighbouring registers
    input wire logic [11:0] pfBaseLow,
    input wire logic [11:0] pfLimitLow,
    input wire logic [3:0] ioBaseLow,
    input wire logic [3:0] ioLimitLow,
    // Request to classify
    input wire logic reqValid,
    input wire logic reqIsIo,
    input wire logic [63:0] reqAddr,
    output logic decValid,
    output logic fwdDown,
    output logic fwdUp,
    // Secondary side events
    input wire logic poisonIn,
    input wire logic errMsgIn,
    input wire logic hotplugIn,
    output logic poisonReport,
    output logic errMsgFwd,
    output logic intaWire,
    // Pin byte loader from management bus or configuration memory, and the interrupt output
    input wire logic isDownstream,
    input wire logic pinLoad,
    input wire logic [7:0] pinLoadValue,
    output logic irq
);
    // Software visible state
    logic [31:0] pfBaseHi_r;
    logic [31:0] pfLimitHi_r;
    logic [15:0] ioBaseHi_r;
    logic [15:0] ioLimitHi_r;
    logic [7:0] intLine_r;
    logic [7:0] intPin_r;
    logic [3:0] bridgeCtl_r;
    logic [2:0] irqStatus_r;
    logic [2:0] irqMask_r;
    logic [2:0] irqSet;
    // Bus tracking
    bwc_pkg::bwc_bus_t busState_r;
    logic wrPend_r;
    logic [7:0] dataAddr_r;
    logic [31:0] rdData_r;
    logic accept;
    // Decision outputs
    logic decValid_r;
    logic fwdDown_r;
    logic fwdUp_r;
    logic poisonReport_r;
    logic errMsgFwd_r;

    // Register read decode, used for the bus and nowhere else wider
    function automatic logic [31:0] readMux(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            bwc_pkg::OFF_PF_BASE_HI: v = pfBaseHi_r;
            bwc_pkg::OFF_PF_LIMIT_HI: v = pfLimitHi_r;
            bwc_pkg::OFF_IO_HI: v = {ioLimitHi_r, ioBaseHi_r};
            bwc_pkg::OFF_CAP_PTR: v = {24'h000000, bwc_pkg::RST_CAP_PTR};
            bwc_pkg::OFF_INT_BRIDGE: v = {12'h000, bridgeCtl_r, intPin_r, intLine_r};
            bwc_pkg::OFF_IRQ_STATUS: v = {29'h0000_0000, irqStatus_r};
            bwc_pkg::OFF_IRQ_MASK: v = {29'h0000_0000, irqMask_r};
            default: v = 32'h0000_0000; // Unmapped reads as zero
        endcase
        return v;
    endfunction

    // Word-in-range test shared by the window and VGA decode
    function automatic logic inRange(input logic [63:0] x, input logic [63:0] lo,
                                     input logic [63:0] hi);
        return (x >= lo) && (x <= hi);
    endfunction

    // Address phase is taken only when the bus is ready
    assign accept = hsel && (htrans == bwc_pkg::HTRANS_NONSEQ) && hready;
    // Reads take one wait state so the data comes from a flop
    assign hreadyout = clkEn && (busState_r != bwc_pkg::BWC_RDWAIT);
    assign hresp = bwc_pkg::HRESP_OKAY;
    assign hrdata = rdData_r;

    // Bus phase tracker
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busState_r <= bwc_pkg::BWC_IDLE;
        end else if (clkEn) begin
            unique case (busState_r)
                bwc_pkg::BWC_RDWAIT: busState_r <= bwc_pkg::BWC_RDDATA;
                default: begin
                    // Idle or last read cycle: a new address phase may start
                    if (accept && !hwrite) begin
                        busState_r <= bwc_pkg::BWC_RDWAIT;
                    end else begin
                        busState_r <= bwc_pkg::BWC_IDLE;
                    end
                end
            endcase
        end
    end

    // Address capture for the following data phase
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wrPend_r <= 1'b0;
            dataAddr_r <= 8'h00;
        end else if (clkEn) begin
            // Writes have no wait state, so hready is high in their data phase
            wrPend_r <= accept && hwrite && (busState_r != bwc_pkg::BWC_RDWAIT);
            if (accept && (busState_r != bwc_pkg::BWC_RDWAIT)) begin
                dataAddr_r <= {haddr[7:2], 2'b00};
            end
        end
    end

    // Read data loaded in the wait cycle, after any earlier write landed
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdData_r <= 32'h0000_0000;
        end else if (clkEn && busState_r == bwc_pkg::BWC_RDWAIT) begin
            rdData_r <= readMux(dataAddr_r);
        end
    end

    // Prefetch window upper words
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pfBaseHi_r <= bwc_pkg::RST_PF_HI;
            pfLimitHi_r <= bwc_pkg::RST_PF_HI;
        end else if (clkEn && wrPend_r) begin
            if (dataAddr_r == bwc_pkg::OFF_PF_BASE_HI) begin
                pfBaseHi_r <= hwdata;
            end
            if (dataAddr_r == bwc_pkg::OFF_PF_LIMIT_HI) begin
                pfLimitHi_r <= hwdata;
            end
        end
    end

    // I/O window upper halves share one word
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ioBaseHi_r <= bwc_pkg::RST_IO_HI;
            ioLimitHi_r <= bwc_pkg::RST_IO_HI;
        end else if (clkEn && wrPend_r && dataAddr_r == bwc_pkg::OFF_IO_HI) begin
            ioBaseHi_r <= hwdata[15:0];
            ioLimitHi_r <= hwdata[bwc_pkg::IO_LIMIT_LSB +: 16];
        end
    end

    // Interrupt line and bridge control; reserved bits are dropped
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            intLine_r <= bwc_pkg::RST_INT_LINE;
            bridgeCtl_r <= bwc_pkg::RST_BRIDGE_CTL;
        end else if (clkEn && wrPend_r && dataAddr_r == bwc_pkg::OFF_INT_BRIDGE) begin
            intLine_r <= hwdata[7:0];
            bridgeCtl_r <= hwdata[bwc_pkg::BC_LSB +: 4];
        end
    end

    // Pin byte: software cannot write it, only the loader on downstream ports
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            intPin_r <= bwc_pkg::RST_INT_PIN;
        end else if (clkEn && pinLoad && isDownstream) begin
            intPin_r <= pinLoadValue;
        end
    end

    // Events into the sticky status
    always_comb begin
        irqSet = 3'h0;
        irqSet[bwc_pkg::IRQ_POISON] = poisonIn && bridgeCtl_r[bwc_pkg::BC_PARITY];
        irqSet[bwc_pkg::IRQ_ERRFWD] = errMsgIn && bridgeCtl_r[bwc_pkg::BC_ERRFWD];
        irqSet[bwc_pkg::IRQ_HOTPLUG] = hotplugIn;
    end

    // Status is write-one-to-clear; a new event in the same cycle wins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irqStatus_r <= bwc_pkg::RST_IRQ;
        end else if (clkEn) begin
            if (wrPend_r && dataAddr_r == bwc_pkg::OFF_IRQ_STATUS) begin
                irqStatus_r <= (irqStatus_r & ~hwdata[2:0]) | irqSet;
            end else begin
                irqStatus_r <= irqStatus_r | irqSet;
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irqMask_r <= bwc_pkg::RST_IRQ;
        end else if (clkEn && wrPend_r && dataAddr_r == bwc_pkg::OFF_IRQ_MASK) begin
            irqMask_r <= hwdata[2:0];
        end
    end

    assign irq = |(irqStatus_r & irqMask_r);
    // Virtual wire follows the sticky hot-plug bit until software clears it
    assign intaWire = irqStatus_r[bwc_pkg::IRQ_HOTPLUG];

    // Secondary side reporting; with the enables clear the events vanish
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            poisonReport_r <= 1'b0;
            errMsgFwd_r <= 1'b0;
        end else if (clkEn) begin
            poisonReport_r <= irqSet[bwc_pkg::IRQ_POISON];
            errMsgFwd_r <= irqSet[bwc_pkg::IRQ_ERRFWD];
        end
    end

    assign poisonReport = poisonReport_r;
    assign errMsgFwd = errMsgFwd_r;

    // Window decode; combinational so the decision costs one flop stage
    logic [63:0] pfBase;
    logic [63:0] pfLimit;
    logic [63:0] ioBase;
    logic [63:0] ioLimit;
    logic inWin;
    logic isaUp;
    logic vgaHit;
    always_comb begin
        pfBase = {pfBaseHi_r, pfBaseLow, bwc_pkg::PF_LOW_ZERO};
        pfLimit = {pfLimitHi_r, pfLimitLow, bwc_pkg::PF_LOW_ONES};
        ioBase = {32'h0000_0000, ioBaseHi_r, ioBaseLow, bwc_pkg::IO_LOW_ZERO};
        ioLimit = {32'h0000_0000, ioLimitHi_r, ioLimitLow, bwc_pkg::IO_LOW_ONES};
        // Inclusive compare on both bounds
        inWin = reqIsIo ? inRange(reqAddr, ioBase, ioLimit)
                        : inRange(reqAddr, pfBase, pfLimit);
        // Upper 768 bytes of each 1KB block below 64KB
        isaUp = reqIsIo && inWin && bridgeCtl_r[bwc_pkg::BC_ISA]
                && (reqAddr <= bwc_pkg::IO_64K_TOP)
                && (reqAddr[9:8] != 2'b00);
        // VGA I/O decode only looks below 64KB, ten-bit aliases
        if (reqIsIo) begin
            vgaHit = (reqAddr <= bwc_pkg::IO_64K_TOP)
                     && (((reqAddr[9:0] >= bwc_pkg::VGA_IO_A_LO)
                          && (reqAddr[9:0] <= bwc_pkg::VGA_IO_A_HI))
                         || ((reqAddr[9:0] >= bwc_pkg::VGA_IO_B_LO)
                             && (reqAddr[9:0] <= bwc_pkg::VGA_IO_B_HI)));
        end else begin
            vgaHit = inRange(reqAddr, bwc_pkg::VGA_MEM_LO, bwc_pkg::VGA_MEM_HI);
        end
    end

    // Registered forwarding decision
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            decValid_r <= 1'b0;
            fwdDown_r <= 1'b0;
            fwdUp_r <= 1'b0;
        end else if (clkEn) begin
            decValid_r <= reqValid;
            if (!reqValid) begin
                fwdDown_r <= 1'b0;
                fwdUp_r <= 1'b0;
            end else if (vgaHit) begin
                // Disabled VGA range is ignored outright
                fwdDown_r <= bridgeCtl_r[bwc_pkg::BC_VGA];
                fwdUp_r <= 1'b0;
            end else begin
                fwdDown_r <= inWin && !isaUp;
                fwdUp_r <= isaUp;
            end
        end
    end

    assign decValid = decValid_r;
    assign fwdDown = fwdDown_r;
    assign fwdUp = fwdUp_r;

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // Register writes land one cycle after their data phase
    AST_PF_BASE: assert property (
        clkEn && wrPend_r && dataAddr_r == bwc_pkg::OFF_PF_BASE_HI
        |=> pfBaseHi_r == $past(hwdata))
        else $error("prefetch base upper word not written");
    AST_PF_LIMIT: assert property (
        clkEn && wrPend_r && dataAddr_r == bwc_pkg::OFF_PF_LIMIT_HI
        |=> pfLimitHi_r == $past(hwdata))
        else $error("prefetch limit upper word not written");
    AST_IO_BASE: assert property (
        clkEn && accept && hwrite && haddr == bwc_pkg::OFF_IO_HI
        && busState_r != bwc_pkg::BWC_RDWAIT ##1 clkEn
        |=> ioBaseHi_r == $past(hwdata[15:0]))
        else $error("io base half wrong after write");
    AST_IO_LIMIT: assert property (
        clkEn && wrPend_r && dataAddr_r == bwc_pkg::OFF_IO_HI
        |=> ioLimitHi_r == $past(hwdata[31:16]))
        else $error("io limit half wrong after write");
    // Read of the fixed pointer after its one wait state
    AST_CAP_READ: assert property (
        clkEn && accept && !hwrite && haddr == bwc_pkg::OFF_CAP_PTR
        && busState_r != bwc_pkg::BWC_RDWAIT ##1 clkEn[*2]
        |-> hreadyout && hrdata == 32'h0000_0040)
        else $error("capability pointer read wrong");
    AST_PIN_LOAD: assert property (
        clkEn && pinLoad && isDownstream |=> intPin_r == $past(pinLoadValue))
        else $error("pin byte not reloaded");
    AST_HOTPLUG: assert property (clkEn && hotplugIn |=> intaWire)
        else $error("hot-plug did not raise virtual wire");
    // Side outputs follow their enables one cycle late
    AST_POISON: assert property (
        clkEn && poisonIn |=> poisonReport == $past(bridgeCtl_r[bwc_pkg::BC_PARITY]))
        else $error("poison report does not follow enable");
    AST_ERRFWD: assert property (
        errMsgFwd |-> $past(bridgeCtl_r[bwc_pkg::BC_ERRFWD]) && $past(errMsgIn))
        else $error("error message forwarded while disabled");
    AST_ISA_UP: assert property (
        fwdUp |-> $past(bridgeCtl_r[bwc_pkg::BC_ISA]) && $past(reqAddr[9:8]) != 2'b00
        && !fwdDown)
        else $error("upstream forward without ISA conditions");
    AST_VGA_MEM: assert property (
        clkEn && reqValid && !reqIsIo
        && reqAddr >= bwc_pkg::VGA_MEM_LO && reqAddr <= bwc_pkg::VGA_MEM_HI
        |=> fwdDown == $past(bridgeCtl_r[bwc_pkg::BC_VGA]))
        else $error("VGA memory forward does not follow enable");
    // Every request gets its decision on the next enabled edge
    AST_DEC_VALID: assert property (clkEn && reqValid |=> decValid)
        else $error("decision not valid after request");
    // A clear racing an event must not lose the event
    AST_SET_WINS: assert property (
        clkEn && irqSet != 3'h0 |=> (irqStatus_r & $past(irqSet)) == $past(irqSet))
        else $error("status event lost");
    // Clock enable low holds all state, so a stalled host sees nothing move
    AST_FREEZE: assert property (
        !clkEn |=> $stable(pfBaseHi_r) && $stable(pfLimitHi_r) && $stable(ioBaseHi_r)
        && $stable(ioLimitHi_r) && $stable(bridgeCtl_r) && $stable(intPin_r)
        && $stable(irqStatus_r) && $stable(irqMask_r) && $stable(busState_r))
        else $error("state moved while clock enable low");

    // Scenarios worth seeing at least once
    COV_READ: cover property (accept && !hwrite ##2 hreadyout);
    COV_FREEZE: cover property (!clkEn && hotplugIn);
    COV_W1C_RACE: cover property (wrPend_r && dataAddr_r == bwc_pkg::OFF_IRQ_STATUS
        && hotplugIn);
    COV_ISA: cover property (fwdUp);
    COV_IRQ: cover property (irq);
endmodule

//--- bwc_tb.sv
`timescale 1ns/1ps
// Compares each read and decision result against the bench's own model
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value at %0t got %h exp %h", $time, (got), (exp)); end end
module testbench;
    logic clk_sys, reset_n, clkEn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [11:0] pfBaseLow, pfLimitLow;
    logic [3:0] ioBaseLow, ioLimitLow;
    logic reqValid, reqIsIo, decValid, fwdDown, fwdUp;
    logic [63:0] reqAddr;
    logic poisonIn, errMsgIn, hotplugIn, poisonReport, errMsgFwd, intaWire, irq;
    logic isDownstream, pinLoad;
    logic [7:0] pinLoadValue;
    // Model state, kept apart from anything the design drives
    logic [31:0] mPfB, mPfL, mIo;
    logic [7:0] mLine, mPin;
    logic [3:0] mBc;
    logic [2:0] mSt, mMk;
    int fail_count, cmp_count;
    // Single slave, so its own ready is the bus ready
    assign hready = hreadyout;
    bwc_bridge_window_regs u_bwc_bridge_window_regs (.clk_sys(clk_sys), .reset_n(reset_n),
        .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pfBaseLow(pfBaseLow), .pfLimitLow(pfLimitLow),
        .ioBaseLow(ioBaseLow), .ioLimitLow(ioLimitLow), .reqValid(reqValid),
        .reqIsIo(reqIsIo), .reqAddr(reqAddr), .decValid(decValid), .fwdDown(fwdDown),
        .fwdUp(fwdUp), .poisonIn(poisonIn), .errMsgIn(errMsgIn), .hotplugIn(hotplugIn),
        .poisonReport(poisonReport), .errMsgFwd(errMsgFwd), .intaWire(intaWire),
        .isDownstream(isDownstream), .pinLoad(pinLoad), .pinLoadValue(pinLoadValue),
        .irq(irq));
    // Free running 250 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Single exit point for every ending
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Mid-cycle sample equals what the next rising edge sees
    task automatic waitRdy();
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            fail_count++;
            finish_test();
        end
    endtask
    // One single AHB-Lite transfer; address phase held until ready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= bwc_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        waitRdy();
        @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        waitRdy();
        rd = hrdata;
        @(posedge clk_sys);
    endtask
    // Expected read value of each word
    function automatic logic [31:0] expRead(input logic [7:0] a);
        case (a)
            8'h28: return mPfB;
            8'h2c: return mPfL;
            8'h30: return mIo;
            8'h34: return 32'h0000_0040;
            8'h3c: return {12'h000, mBc, mPin, mLine};
            8'h80: return {29'h0, mSt};
            8'h84: return {29'h0, mMk};
            default: return 32'h0000_0000;
        endcase
    endfunction
    // Write through the bus and mirror it in the model
    task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        case (a)
            8'h28: mPfB = d;
            8'h2c: mPfL = d;
            8'h30: mIo = d;
            8'h3c: begin
                mLine = d[7:0];
                mBc = d[19:16];
            end
            8'h80: mSt = mSt & ~d[2:0];
            8'h84: mMk = d[2:0];
            default: ;
        endcase
    endtask
    task automatic rdChk(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
        `CHK(rd, expRead(a))
    endtask
    // Expected {down, up} decision for one request
    function automatic logic [1:0] decide(input logic io, input logic [63:0] a);
        logic [63:0] lo, hi;
        logic vga, inW, isa;
        vga = io ? (a <= 64'hffff && ((a[9:0] >= 10'h3b0 && a[9:0] <= 10'h3bb) ||
            (a[9:0] >= 10'h3c0 && a[9:0] <= 10'h3df))) : (a >= 64'ha0000 && a <= 64'hbffff);
        lo = io ? {32'h0, mIo[15:0], ioBaseLow, 12'h000} : {mPfB, pfBaseLow, 20'h00000};
        hi = io ? {32'h0, mIo[31:16], ioLimitLow, 12'hfff} : {mPfL, pfLimitLow, 20'hfffff};
        inW = a >= lo && a <= hi;
        isa = io && inW && mBc[2] && a <= 64'hffff && a[9:8] != 2'b00;
        if (vga) begin
            return {mBc[3], 1'b0};
        end
        return {inW && !isa, isa};
    endfunction
    // One request in, one decision out on the next cycle
    task automatic dec(input logic io, input logic [63:0] a);
        @(posedge clk_sys);
        reqValid <= 1'b1;
        reqIsIo <= io;
        reqAddr <= a;
        @(posedge clk_sys);
        reqValid <= 1'b0;
        @(negedge clk_sys);
        `CHK(decValid, 1'b1)
        `CHK({fwdDown, fwdUp}, decide(io, a))
    endtask
    initial begin
        {reset_n, hsel, hwrite, reqValid, reqIsIo, poisonIn, errMsgIn, hotplugIn} = '0;
        {isDownstream, pinLoad, pinLoadValue, haddr, htrans, hsize, hwdata, reqAddr} = '0;
        {pfBaseLow, pfLimitLow, ioBaseLow, ioLimitLow} = '0;
        {mPfB, mPfL, mIo, mLine, mPin, mBc, mSt, mMk} = '0;
        clkEn = 1'b1;
        fail_count = 0;
        cmp_count = 0;
        void'($urandom(32'hd91f658d));
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        // Reset values, then random writes including read-only and unmapped places
        for (int i = 0; i < 9; i++) begin
            rdChk(i < 8 ? 8'h28 + 8'(i * 4) : 8'h3c);
        end
        for (int i = 0; i < 8; i++) begin
            wrReg(8'h28 + 8'(i * 4), $urandom);
            rdChk(8'h28 + 8'(i * 4));
        end
        wrReg(8'h3c, $urandom);
        rdChk(8'h3c);
        rdChk(8'hfc);
        `CHK(hresp, 1'b0)
        $display("test registers done");
        // Window and legacy forwarding under every bridge control setting
        wrReg(8'h30, 32'h0);
        for (int b = 0; b < 16; b++) begin
            wrReg(8'h3c, {12'h0, 4'(b), 16'h0});
            wrReg(8'h28, 32'($urandom_range(0, 3)));
            wrReg(8'h2c, mPfB + 32'($urandom_range(0, 1)));
            @(posedge clk_sys);
            pfBaseLow <= 12'($urandom_range(16, 200));
            pfLimitLow <= 12'($urandom_range(200, 400));
            ioBaseLow <= 4'($urandom_range(1, 4));
            ioLimitLow <= 4'($urandom_range(4, 7));
            @(posedge clk_sys);
            dec(1'b0, {mPfB, pfBaseLow, 20'h00000});
            dec(1'b0, {mPfL, pfLimitLow, 20'hfffff});
            dec(1'b0, {mPfL, pfLimitLow, 20'hfffff} + 64'h1);
            dec(1'b1, {32'h0, mIo[15:0], ioBaseLow, 12'h000});
            dec(1'b1, 64'h0001_03c0);
            for (int k = 0; k < 6; k++) begin
                dec(1'b0, {mPfB, 12'($urandom_range(0, 450)), 20'($urandom)});
                dec(1'b0, 64'($urandom_range(32'h9_0000, 32'hc_ffff)));
                dec(1'b1, 64'($urandom_range(0, 32'h9fff)));
            end
        end
        $display("test decode done");
        // Event reporting with enables off and on, then masking and clearing
        for (int en = 0; en < 2; en++) begin
            wrReg(8'h3c, {14'h0, en[0], en[0], 16'h0});
            @(posedge clk_sys);
            {poisonIn, errMsgIn, hotplugIn} <= 3'b111;
            @(posedge clk_sys);
            {poisonIn, errMsgIn, hotplugIn} <= 3'b000;
            mSt = {1'b1, en[0], en[0]};
            @(negedge clk_sys);
            `CHK(poisonReport, en[0])
            `CHK(errMsgFwd, en[0])
            `CHK(intaWire, 1'b1)
            `CHK(irq, 1'b0)
            rdChk(8'h80);
            wrReg(8'h84, 32'h7);
            // Mask lands at the edge the task returns on; look once it has settled
            @(negedge clk_sys);
            `CHK(irq, 1'b1)
            wrReg(8'h80, 32'h7);
            rdChk(8'h80);
            `CHK(irq, 1'b0)
            `CHK(intaWire, 1'b0)
            wrReg(8'h84, 32'h0);
        end
        $display("test events done");
        // Clock enable low: an event must leave no trace and the bus must stall
        @(posedge clk_sys);
        clkEn <= 1'b0;
        hotplugIn <= 1'b1;
        @(posedge clk_sys);
        hotplugIn <= 1'b0;
        @(negedge clk_sys);
        `CHK(hreadyout, 1'b0)
        `CHK(intaWire, 1'b0)
        @(posedge clk_sys);
        clkEn <= 1'b1;
        rdChk(8'h80);
        $display("test freeze done");
        // Pin byte override, honoured only on a downstream port
        for (int d = 1; d >= 0; d--) begin
            @(posedge clk_sys);
            isDownstream <= d[0];
            pinLoad <= 1'b1;
            pinLoadValue <= 8'($urandom);
            @(posedge clk_sys);
            pinLoad <= 1'b0;
            if (d == 1) begin
                mPin = pinLoadValue;
            end
            rdChk(8'h3c);
        end
        $display("test pin load done");
        finish_test();
    end
endmodule
